/* psst_host.sv */
`default_nettype none
// ****************************************
// Host processor driving the register port
// ****************************************
module psst_host
  import psst_pkg::*;
(
  input  wire logic          clk,       // System clock
  input  wire logic          bpEnable,  // Lets backplane clocks run
  input  wire logic [7:0]    cpuRdData, // Register read data
  output var  psst_cpu_req_t cpuReq,    // Register request
  output var  logic          hwRstN,    // Hardware reset pin
  output logic               rxBp,      // Receive backplane clock
  output logic [3:0]         txBp       // Transmit backplane clocks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bpTog;

  // Free toggle, unrelated in phase to clk
  initial begin
    bpTog = 1'b0;
    forever #7 bpTog = ~bpTog;
  end
  // Clocks rest low after reset unless the bench lets them run
  assign rxBp = bpEnable & bpTog;
  assign txBp = {4{bpEnable & bpTog}};
  initial begin
    cpuReq = '0;
    hwRstN = 1'b1;
  end

  // One-cycle pulses launched on the falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    cpuReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk);
    cpuReq = '0;
  endtask : wr
  // Read data is taken one cycle after the request edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    cpuReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge clk);
    d = cpuRdData;
    cpuReq = '0;
  endtask : rd
  // Bounded poll, so a stuck busy flag cannot hang the run
  task automatic waitIdle(input logic [6:0] st);
    logic [7:0] s;
    int n;
    s = 8'hFF;
    n = 0;
    while (s[7] !== 1'b0 && n < 20) begin
      rd(st, s);
      n++;
    end
  endtask : waitIdle
  task automatic indWr(input logic [6:0] b, input logic [6:0] ia, input logic [7:0] d);
    waitIdle(b + 7'h01);
    wr(b + 7'h03, d);
    wr(b + 7'h02, {1'b0, ia});
    waitIdle(b + 7'h01);
  endtask : indWr
  task automatic indRd(input logic [6:0] b, input logic [6:0] ia, output logic [7:0] d);
    waitIdle(b + 7'h01);
    wr(b + 7'h02, {1'b1, ia});
    waitIdle(b + 7'h01);
    rd(b + 7'h03, d);
  endtask : indRd
  task automatic hwReset;
    @(negedge clk);
    hwRstN = 1'b0;
    repeat (4) @(negedge clk);
    hwRstN = 1'b1;
    repeat (4) @(negedge clk);
  endtask : hwReset
  // Channel entries loaded before the outputs are enabled
  task automatic prepare(input logic [7:0] idle);
    wr(7'h30, 8'h02);
    for (int e = 0; e < 64; e++) begin
      if (e == 0 || e == 16) continue;
      indWr(7'h30, 7'(e), (e < 32) ? 8'hF5 : idle);
    end
    wr(7'h30, 8'h03);
  endtask : prepare
  task automatic sigxCfg;
    wr(7'h40, 8'h02);
    for (int s = 0; s < 32; s++) begin
      indWr(7'h40, 7'(s), (s == 0 || s == 16) ? 8'h00 : 8'h10);
    end
    wr(7'h40, 8'h03);
  endtask : sigxCfg
  task automatic loopCfg;
    wr(7'h0A, 8'h04);
    wr(7'h10, 8'h00);
    wr(7'h44, 8'h70);
    wr(7'h20, 8'h80);
    wr(7'h00, 8'h20);
  endtask : loopCfg
  // Lock needs two clean state polls and clean flags on the second
  task automatic lock(output logic ok);
    logic [7:0] a, b, f;
    int n;
    ok = 1'b0;
    n = 0;
    b = 8'hFF;
    while (!ok && n < 40) begin
      a = b;
      rd(7'h26, b);
      rd(7'h24, f);
      ok = (a[2:0] === 3'h0) && (b[2:0] === 3'h0) && (f[2:0] === 3'h0);
      n++;
    end
  endtask : lock
endmodule : psst_host
`default_nettype wire

/* psst_mem.sv */
`default_nettype none
// Indirect storage; no reset so contents survive any block reset
module psst_mem #(
  parameter int AW = 5
) (
  input  wire logic          clk,     // System clock
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [7:0]    wdata,   // Write data
  input  wire logic [AW-1:0] raddrA,  // Host read address
  output logic      [7:0]    rdataA,  // Host read data, registered
  input  wire logic [AW-1:0] raddrB,  // Engine read address
  output logic      [7:0]    rdataB   // Engine read data, registered
);

  logic [7:0] store [0:(1<<AW)-1];

  // Write and registered reads
  always_ff @(posedge clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    rdataA <= store[raddrA];
    rdataB <= store[raddrB];
  end

endmodule : psst_mem
`default_nettype wire

/* psst_params.svh */
`ifndef PSST_PARAMS_SVH
`define PSST_PARAMS_SVH

// ****************************************
// Register offsets within one quadrant
// ****************************************
`define PSST_REG_RX_OPTIONS      7'h00
`define PSST_REG_LOOPBACK        7'h0A
`define PSST_REG_RESET_CTRL      7'h0D
`define PSST_REG_TX_LINE_OPT     7'h10
`define PSST_REG_FRAMER_CFG      7'h20
`define PSST_REG_CHANGE_FLAGS    7'h24
`define PSST_REG_ALIGN_STATE     7'h26
`define PSST_REG_PCC_CONFIG      7'h30
`define PSST_REG_PCC_STATUS      7'h31
`define PSST_REG_PCC_ADDR_CTRL   7'h32
`define PSST_REG_PCC_DATA        7'h33
`define PSST_REG_SIGNALING_EXTRACTOR_CONFIG     7'h40
`define PSST_REG_SIGNALING_EXTRACTOR_STATUS     7'h41
`define PSST_REG_SIGNALING_EXTRACTOR_ADDR_CTRL  7'h42
`define PSST_REG_SIGNALING_EXTRACTOR_DATA       7'h43
`define PSST_REG_CRC_GEN         7'h44

// ****************************************
// Field positions and values
// ****************************************
`define PSST_BIT_RESET           0
`define PSST_BIT_PER_CHANNEL_ENABLE            0
`define PSST_BIT_IND             1
`define PSST_BIT_BUSY            7
`define PSST_BIT_RWSEL           7
`define PSST_BIT_DEBOUNCE        4
`define PSST_BIT_CRC_FRAMING     7
`define PSST_BIT_SIGNALING_EXTRACTOR_AREA       5
`define PSST_REG_RESET_VALUE     8'h00
`define PSST_LOOPBACK_DIAG       8'h04
`define PSST_SLOT_ZERO           5'h00
`define PSST_SLOT_SIXTEEN        5'h10

// ****************************************
// Timing
// ****************************************
`define PSST_CLK_PERIOD_NS       10
`define PSST_BPCLK_HOLD_NS       65
`define PSST_BPCLK_HOLD_CYCLES   ((`PSST_BPCLK_HOLD_NS + `PSST_CLK_PERIOD_NS - 1) / `PSST_CLK_PERIOD_NS)
`define PSST_LOCK_CYCLES         64

`endif

/* psst_pkg.sv */
`default_nettype none
package psst_pkg;

  // Register port request from the host
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } psst_cpu_req_t;

  // One indirect access controller
  typedef struct packed {
    logic       busy;
    logic       stage;
    logic       isRead;
    logic [6:0] addr;
    logic [7:0] data;
  } psst_ind_t;

  typedef enum logic [1:0] { EX_SETTLE, EX_RUN, EX_FROZEN } psst_ext_state_t;

endpackage : psst_pkg
`default_nettype wire

/* psst_quadrant.sv */
`include "psst_params.svh"
`default_nettype none
// What this block does
// - Extractor state machine may freeze in the EX_FROZEN state (2'b10) after reset.
// - Reset restores normal registers; indirect registers keep contents.
// - Data control F5H makes the device send signaling 0101 per channel.
// - Loopback value 04H routes transmit data into own receiver.
// - Data control FFH makes the device send signaling 1111.
module psst_quadrant
  import psst_pkg::*;
(
  input  wire logic          clk,               // 100 MHz clock
  input  wire logic          rstn,              // Synchronous reset, active low
  input  wire logic          hwResetPinN,       // Hardware reset pin, asynchronous
  input  wire logic          rxBackplaneClock,  // Receive backplane clock pin
  input  wire logic [3:0]    txBackplaneClocks, // Transmit backplane clock pins
  input  wire logic [2:0]    lineAlignLoss,     // Line aligner state pins
  input  wire logic [3:0]    lineRxSignaling,   // Received ABCD from the line
  input  wire psst_cpu_req_t cpuReq,            // Register port request
  output logic      [7:0]    cpuRdData,         // Register read data
  output logic      [4:0]    txSlot,            // Timeslot of txSignaling
  output logic      [3:0]    txSignaling,       // Transmitted ABCD
  output logic               loopbackActive,    // Diagnostic loopback on
  output logic               extractorFrozen    // Extractor stuck state
);

  // ****************************************
  // Pin synchronisers and reset tree
  // ****************************************
  logic [9:0]  pinMeta, pinSync;
  logic        blockRst, hardRst;
  logic [7:0]  resetCtrl;

  // Two stages per pin; align bits rest at the loss level so reset leaves no false change
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinMeta <= 10'h039;
      pinSync <= 10'h039;
    end else begin
      pinMeta <= {lineRxSignaling, lineAlignLoss, (|txBackplaneClocks), rxBackplaneClock, hwResetPinN};
      pinSync <= pinMeta;
    end
  end

  assign hardRst  = !rstn || !pinSync[0];
  assign blockRst = hardRst || resetCtrl[`PSST_BIT_RESET];

  // Reset bit itself only follows the pin and rstn
  always_ff @(posedge clk) begin
    if (hardRst) begin
      resetCtrl <= `PSST_REG_RESET_VALUE;
    end else if (cpuReq.wr && cpuReq.addr == `PSST_REG_RESET_CTRL) begin
      resetCtrl <= cpuReq.data;
    end
  end

  // ****************************************
  // Normal mode registers
  // ****************************************
  logic [7:0] rxOptions, loopbackCtrl, txLineOpt, framerCfg, pccConfig, sigxConfig, crcGen;

  // Every normal register returns to default on any reset
  always_ff @(posedge clk) begin
    if (blockRst) begin
      rxOptions    <= `PSST_REG_RESET_VALUE;
      loopbackCtrl <= `PSST_REG_RESET_VALUE;
      txLineOpt    <= `PSST_REG_RESET_VALUE;
      framerCfg    <= `PSST_REG_RESET_VALUE;
      pccConfig    <= `PSST_REG_RESET_VALUE;
      sigxConfig   <= `PSST_REG_RESET_VALUE;
      crcGen       <= `PSST_REG_RESET_VALUE;
    end else if (cpuReq.wr) begin
      case (cpuReq.addr)
        `PSST_REG_RX_OPTIONS:  rxOptions    <= cpuReq.data;
        `PSST_REG_LOOPBACK:    loopbackCtrl <= cpuReq.data;
        `PSST_REG_TX_LINE_OPT: txLineOpt    <= cpuReq.data;
        `PSST_REG_FRAMER_CFG:  framerCfg    <= cpuReq.data;
        `PSST_REG_PCC_CONFIG:  pccConfig    <= cpuReq.data;
        `PSST_REG_SIGNALING_EXTRACTOR_CONFIG: sigxConfig   <= cpuReq.data;
        `PSST_REG_CRC_GEN:     crcGen       <= cpuReq.data;
        default: ;
      endcase
    end
  end

  assign loopbackActive = (loopbackCtrl == `PSST_LOOPBACK_DIAG);

  // ****************************************
  // Frame aligner state and change flags
  // ****************************************
  logic [6:0] lockCnt;
  logic [2:0] alignState, changeFlags;
  logic       flagsRead;

  // Looped-back frames lock after a fixed settling time once CRC framing is on
  always_ff @(posedge clk) begin
    if (blockRst || !(loopbackActive && framerCfg[`PSST_BIT_CRC_FRAMING])) begin
      lockCnt <= 7'h00;
    end else if (lockCnt != 7'(`PSST_LOCK_CYCLES)) begin
      lockCnt <= lockCnt + 7'h01;
    end
  end

  assign flagsRead = cpuReq.rd && cpuReq.addr == `PSST_REG_CHANGE_FLAGS;

  // Flags are sticky; a new change beats a clearing read
  always_ff @(posedge clk) begin
    if (blockRst) begin
      alignState  <= 3'h7;
      changeFlags <= 3'h0;
    end else begin
      alignState  <= loopbackActive ? ((lockCnt == 7'(`PSST_LOCK_CYCLES)) ? 3'h0 : 3'h7) : pinSync[5:3];
      changeFlags <= (flagsRead ? 3'h0 : changeFlags) | (alignState ^ (loopbackActive ?
                     ((lockCnt == 7'(`PSST_LOCK_CYCLES)) ? 3'h0 : 3'h7) : pinSync[5:3]));
    end
  end

  // ****************************************
  // Indirect access controllers (0 channel ctl, 1 extractor)
  // ****************************************
  psst_ind_t  indirect_access_select [0:1];
  logic [7:0] pccRdA, pccRdB, cfgRdA, cfgRdB, datRdA, datRdB;

  function automatic logic [6:0] ind_base(input int unit);
    ind_base = (unit == 0) ? `PSST_REG_PCC_STATUS : `PSST_REG_SIGNALING_EXTRACTOR_STATUS;
  endfunction : ind_base

  // Two-cycle busy window per access; requests while busy are dropped
  always_ff @(posedge clk) begin
    for (int u = 0; u < 2; u++) begin
      if (blockRst) begin
        indirect_access_select[u] <= '0;
      end else if (indirect_access_select[u].busy) begin
        indirect_access_select[u].stage <= 1'b1;
        if (indirect_access_select[u].stage) begin
          indirect_access_select[u].busy <= 1'b0;
          if (indirect_access_select[u].isRead) begin
            indirect_access_select[u].data <= (u == 0) ? pccRdA : (indirect_access_select[u].addr[`PSST_BIT_SIGNALING_EXTRACTOR_AREA] ? datRdA : cfgRdA);
          end
        end
      end else if (cpuReq.wr && cpuReq.addr == ind_base(u) + 7'h2) begin
        indirect_access_select[u].data <= cpuReq.data;
      end else if (cpuReq.wr && cpuReq.addr == ind_base(u) + 7'h1 &&
                   ((u == 0) ? pccConfig[`PSST_BIT_IND] : sigxConfig[`PSST_BIT_IND])) begin
        indirect_access_select[u].busy   <= 1'b1;
        indirect_access_select[u].stage  <= 1'b0;
        indirect_access_select[u].isRead <= cpuReq.data[`PSST_BIT_RWSEL];
        indirect_access_select[u].addr   <= cpuReq.data[6:0];
      end
    end
  end

  // ****************************************
  // Extractor settle / freeze state machine
  // ****************************************
  psst_ext_state_t extState;
  logic [3:0]      holdCnt;

  // A backplane clock sampled high inside the hold window corrupts the
  // extractor state; it then stays stuck until the next reset
  always_ff @(posedge clk) begin
    if (blockRst) begin
      extState <= EX_SETTLE;
      holdCnt  <= 4'h0;
    end else begin
      unique case (extState)
        EX_SETTLE: begin
          holdCnt <= holdCnt + 4'h1;
          if (pinSync[1] || pinSync[2]) begin
            extState <= EX_FROZEN;
          end else if (holdCnt == 4'(`PSST_BPCLK_HOLD_CYCLES - 1)) begin
            extState <= EX_RUN;
          end
        end
        EX_RUN:    extState <= EX_RUN;
        EX_FROZEN: extState <= EX_FROZEN;
      endcase
    end
  end

  assign extractorFrozen = (extState == EX_FROZEN);

  // ****************************************
  // Timeslot engine: insertion, loopback, extraction
  // ****************************************
  logic [4:0] slot, slotQ;
  logic       slotActive, pccWe, cfgWe, datWe, engWe;
  logic [3:0] nextTx, rawSig;
  logic [7:0] engData;

  // Slot counter and pipelined slot for the registered reads
  always_ff @(posedge clk) begin
    if (blockRst) begin
      slot  <= 5'h00;
      slotQ <= 5'h00;
    end else begin
      slot  <= slot + 5'h01;
      slotQ <= slot;
    end
  end

  assign slotActive = slotQ != `PSST_SLOT_ZERO && slotQ != `PSST_SLOT_SIXTEEN;
  assign nextTx     = (pccConfig[`PSST_BIT_PER_CHANNEL_ENABLE] && slotActive) ? pccRdB[3:0] : 4'h0;
  assign rawSig     = loopbackActive ? nextTx : pinSync[9:6];

  // Debounced nibble only follows two equal samples in a row
  assign engData = cfgRdB[`PSST_BIT_DEBOUNCE] ?
                   {((rawSig == datRdB[3:0]) ? rawSig : datRdB[7:4]), rawSig} : {rawSig, rawSig};

  assign pccWe = indirect_access_select[0].busy && !indirect_access_select[0].stage && !indirect_access_select[0].isRead;
  assign cfgWe = indirect_access_select[1].busy && !indirect_access_select[1].stage && !indirect_access_select[1].isRead && !indirect_access_select[1].addr[`PSST_BIT_SIGNALING_EXTRACTOR_AREA];
  assign datWe = indirect_access_select[1].busy && !indirect_access_select[1].stage && !indirect_access_select[1].isRead && indirect_access_select[1].addr[`PSST_BIT_SIGNALING_EXTRACTOR_AREA];
  // Host write wins the port; the slot refreshes next frame
  assign engWe = sigxConfig[`PSST_BIT_PER_CHANNEL_ENABLE] && extState == EX_RUN && slotActive && !datWe;

  // Registered transmit signaling
  always_ff @(posedge clk) begin
    if (blockRst) begin
      txSlot      <= 5'h00;
      txSignaling <= 4'h0;
    end else begin
      txSlot      <= slotQ;
      txSignaling <= nextTx;
    end
  end

  psst_mem #(.AW(6)) uPccMem (
    .clk(clk), .we(pccWe), .waddr(indirect_access_select[0].addr[5:0]), .wdata(indirect_access_select[0].data),
    .raddrA(indirect_access_select[0].addr[5:0]), .rdataA(pccRdA), .raddrB({1'b0, slot}), .rdataB(pccRdB)
  );
  psst_mem #(.AW(5)) uSigCfgMem (
    .clk(clk), .we(cfgWe), .waddr(indirect_access_select[1].addr[4:0]), .wdata(indirect_access_select[1].data),
    .raddrA(indirect_access_select[1].addr[4:0]), .rdataA(cfgRdA), .raddrB(slot), .rdataB(cfgRdB)
  );
  psst_mem #(.AW(5)) uSigDatMem (
    .clk(clk), .we(datWe || engWe), .waddr(datWe ? indirect_access_select[1].addr[4:0] : slotQ),
    .wdata(datWe ? indirect_access_select[1].data : engData),
    .raddrA(indirect_access_select[1].addr[4:0]), .rdataA(datRdA), .raddrB(slot), .rdataB(datRdB)
  );

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (blockRst && !hardRst && cpuReq.rd && cpuReq.addr == `PSST_REG_RESET_CTRL) begin
      cpuRdData <= resetCtrl;
    end else if (blockRst) begin
      cpuRdData <= 8'h00;
    end else if (cpuReq.rd) begin
      case (cpuReq.addr)
        `PSST_REG_RX_OPTIONS:     cpuRdData <= rxOptions;
        `PSST_REG_LOOPBACK:       cpuRdData <= loopbackCtrl;
        `PSST_REG_RESET_CTRL:     cpuRdData <= resetCtrl;
        `PSST_REG_TX_LINE_OPT:    cpuRdData <= txLineOpt;
        `PSST_REG_FRAMER_CFG:     cpuRdData <= framerCfg;
        `PSST_REG_CHANGE_FLAGS:   cpuRdData <= {5'h00, changeFlags};
        `PSST_REG_ALIGN_STATE:    cpuRdData <= {5'h00, alignState};
        `PSST_REG_PCC_CONFIG:     cpuRdData <= pccConfig;
        `PSST_REG_PCC_STATUS:     cpuRdData <= {indirect_access_select[0].busy, 7'h00};
        `PSST_REG_PCC_ADDR_CTRL:  cpuRdData <= {indirect_access_select[0].isRead, indirect_access_select[0].addr};
        `PSST_REG_PCC_DATA:       cpuRdData <= indirect_access_select[0].data;
        `PSST_REG_SIGNALING_EXTRACTOR_CONFIG:    cpuRdData <= sigxConfig;
        `PSST_REG_SIGNALING_EXTRACTOR_STATUS:    cpuRdData <= {indirect_access_select[1].busy, 7'h00};
        `PSST_REG_SIGNALING_EXTRACTOR_ADDR_CTRL: cpuRdData <= {indirect_access_select[1].isRead, indirect_access_select[1].addr};
        `PSST_REG_SIGNALING_EXTRACTOR_DATA:      cpuRdData <= indirect_access_select[1].data;
        `PSST_REG_CRC_GEN:        cpuRdData <= crcGen;
        default:                  cpuRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (blockRst);

  tx_insert_value_a: assert property ($past(pccConfig[0]) && $past(slotActive) && !$past(blockRst)
    |-> txSignaling == $past(pccRdB[3:0]))
    else $error("transmitted signaling differs from data control");
  tx_idle_slot_a: assert property (!$past(slotActive) && !$past(blockRst) |-> txSignaling == 4'h0)
    else $error("signaling sent in slot zero or sixteen");
  loop_route_a: assert property (engWe && loopbackActive |=> txSignaling == $past(engData[3:0]))
    else $error("loopback did not route transmit signaling");
  frozen_stuck_a: assert property (extState == EX_FROZEN |=> extState == EX_FROZEN && !engWe ##1 !engWe)
    else $error("frozen extractor resumed");
  regs_default_a: assert property (disable iff (!rstn) $fell(blockRst)
    |-> loopbackCtrl == 8'h00 && pccConfig == 8'h00 && sigxConfig == 8'h00)
    else $error("register not at default after reset");

  cover_frozen_c:   cover property (extState == EX_SETTLE ##1 extState == EX_FROZEN);
  cover_lock_c:     cover property (loopbackActive && $fell(alignState[0]));
  cover_loopback_c: cover property (engWe && loopbackActive && engData == 8'h55);

endmodule : psst_quadrant
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench
  import psst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, bpEnable, hwRstN, rxBp, loopbackActive, extractorFrozen, ok;
  logic [3:0] txBp, lineSig, txSignaling;
  logic [2:0] lineAlign;
  logic [4:0] txSlot;
  logic [7:0] cpuRdData, lfsr, v;
  psst_cpu_req_t cpuReq;
  logic [7:0] dctl [32];
  logic [6:0] regList [10] = '{7'h00, 7'h0A, 7'h0D, 7'h10, 7'h20, 7'h24, 7'h30, 7'h40, 7'h44, 7'h7F};
  int fails, n_compared;

  psst_quadrant DUT (.clk(clk), .rstn(rstn), .hwResetPinN(hwRstN), .rxBackplaneClock(rxBp),
    .txBackplaneClocks(txBp), .lineAlignLoss(lineAlign), .lineRxSignaling(lineSig), .cpuReq(cpuReq),
    .cpuRdData(cpuRdData), .txSlot(txSlot), .txSignaling(txSignaling), .loopbackActive(loopbackActive),
    .extractorFrozen(extractorFrozen));
  psst_host host (.clk(clk), .bpEnable(bpEnable), .cpuRdData(cpuRdData), .cpuReq(cpuReq),
    .hwRstN(hwRstN), .rxBp(rxBp), .txBp(txBp));

  // ****************************************
  // Shared checking tasks
  // ****************************************
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Slots 0 and 16 never carry inserted signaling
  task automatic txCheck;
    logic [7:0] e;
    logic [4:0] p;
    p = txSlot;
    repeat (64) begin
      @(negedge clk);
      p = p + 5'h01;
      chk("txSlot", {3'h0, txSlot}, {3'h0, p});
      e = (txSlot === 5'h00 || txSlot === 5'h10) ? 8'h00 : {4'h0, dctl[txSlot][3:0]};
      chk("txSignaling", {4'h0, txSignaling}, e);
    end
  endtask : txCheck
  task automatic sigCheck;
    for (int s = 1; s < 32; s++) begin
      if (s == 16) continue;
      host.indRd(7'h40, 7'(32 + s), v);
      chk("signaling", v, {dctl[s][3:0], dctl[s][3:0]});
    end
  endtask : sigCheck

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Generous span; the sequence needs only a few thousand cycles
  initial begin
    #500000;
    fails++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    bpEnable = 1'b0;
    lineAlign = 3'h7;
    lfsr = 8'h14;
    lineSig = lfsr[3:0];
    fails = 0;
    n_compared = 0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    foreach (regList[i]) begin
      host.rd(regList[i], v);
      chk("default", v, 8'h00);
    end
    chk("frozen", {7'h0, extractorFrozen}, 8'h00);
    lfsr = lfsrNext(lfsr);
    host.wr(7'h44, lfsr);
    host.rd(7'h44, v);
    chk("crcGen", v, lfsr);
    // Aligner pins show through outside loopback; a move raises sticky change flags
    lineAlign = lfsr[2:0];
    repeat (3) @(negedge clk);
    host.rd(7'h26, v);
    chk("alignState", v, {5'h00, lfsr[2:0]});
    host.rd(7'h24, v);
    chk("changeFlags", v, {5'h00, 3'h7 ^ lfsr[2:0]});
    host.rd(7'h24, v);
    chk("flagsCleared", v, 8'h00);
    // Self-test sequence on this quadrant after reset
    lfsr = lfsrNext(lfsr);
    host.prepare(lfsr);
    for (int s = 0; s < 32; s++) begin
      if (s != 0 && s != 16) dctl[s] = 8'hF5;
    end
    txCheck();
    host.sigxCfg();
    host.indRd(7'h40, 7'd1, v);
    chk("slotConfig", v, 8'h10);
    host.loopCfg();
    chk("loopback", {7'h0, loopbackActive}, 8'h01);
    host.lock(ok);
    chk("lock", {7'h0, ok}, 8'h01);
    repeat (200) @(negedge clk);
    sigCheck();
    for (int s = 1; s < 32; s++) begin
      if (s == 16) continue;
      host.indWr(7'h30, 7'(s), 8'hFF);
      dctl[s] = 8'hFF;
    end
    txCheck();
    repeat (200) @(negedge clk);
    sigCheck();
    // Software reset keeps indirect contents and the reset bit, clears the rest
    host.wr(7'h0D, 8'h01);
    host.rd(7'h0A, v);
    chk("loopbackInReset", v, 8'h00);
    chk("loopbackPin", {7'h0, loopbackActive}, 8'h00);
    host.rd(7'h0D, v);
    chk("resetBit", v, 8'h01);
    host.wr(7'h0D, 8'h00);
    host.rd(7'h30, v);
    chk("pccConfig", v, 8'h00);
    host.wr(7'h30, 8'h02);
    host.indRd(7'h30, 7'd5, v);
    chk("dataControl", v, 8'hFF);
    host.indRd(7'h30, 7'd40, v);
    chk("idleCode", v, lfsr);
    // Backplane clocks running through the hold window freeze the extractor
    host.wr(7'h0A, 8'h04);
    bpEnable = 1'b1;
    host.hwReset();
    repeat (10) @(negedge clk);
    chk("frozenSet", {7'h0, extractorFrozen}, 8'h01);
    bpEnable = 1'b0;
    host.hwReset();
    repeat (10) @(negedge clk);
    chk("frozenClear", {7'h0, extractorFrozen}, 8'h00);
    host.rd(7'h0A, v);
    chk("loopbackAfterPin", v, 8'h00);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
